// ### src/msac_pkg.sv
// constants and carrier types of the multislope adc command control
// assumes one 200 mhz oscillator clock and a separate serial link clock
// What this block does
// - command bits d1,d2 pick next read register
// - select 00 low,01 high,10 status,11 invalid
// - read-zero set shorts inputs for conversion
// - read-zero clear measures positive minus negative input
// - sleep bit sleeps at eoc, counter stops
// - serial interface keeps working while asleep
// - d6 picks 546 or 655 integrate counts
// - start bit runs exactly one conversion
// - eoc high when counter reaches 0000
// - start checked at 0000, counter loads 0001
// - start bit self-clears five cycles after use
// - start cleared after five cycles, before counter wraps to 0000
// - status: collision,eoc,integrating,sleep,negative,b2..b0
// - overrange soft 279040, hard clamp 350440
// - 8-bit msb first, latch on select rise
// - word one d4..d7 drive gp outputs 0..3
// - status read clears the collision flag
package msac_pkg;
    localparam int CNT_W = 11;
    localparam logic [10:0] CNT_ZERO = 11'h000;
    localparam logic [10:0] CNT_FIRST = 11'h001;
    localparam logic [10:0] INT_BEGIN = 11'h010;
    localparam logic [10:0] INT_LEN_60 = 11'h222;
    localparam logic [10:0] INT_LEN_50 = 11'h28f;
    localparam logic [2:0] START_HOLD = 3'h5;
    localparam int RES_W = 19;
    localparam logic [18:0] SOFT_OVR = 19'h44200;
    localparam logic [18:0] HARD_OVR = 19'h558e8;
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] SEL_STAT = 2'h2;
    localparam logic [1:0] SEL_BAD = 2'h3;
    localparam logic [7:0] BAD_BYTE = 8'h00;

    typedef struct packed {
        logic start;
        logic hz50;
        logic sleep;
        logic read_zero;
        logic unused;
        logic reg_select_lo;
        logic reg_select_hi;
        logic word_sel;
    } msac_cmd0_t;

    typedef struct packed {
        logic collision;
        logic eoc;
        logic integrating;
        logic asleep;
        logic negative;
        logic [2:0] low_bits;
    } msac_status_t;

    typedef struct packed {
        logic negative;
        logic [18:0] mag;
    } msac_result_t;
endpackage

// ### src/msac_top.sv
// command, conversion control and serial port of the multislope adc
// assumes analog results arrive on clk; link signals arrive on sclk/cs_n
`timescale 1ns/1ps
module msac_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    input wire msac_pkg::msac_result_t result_in,
    output logic eoc,
    output logic integrating,
    output logic input_short,
    output logic [10:0] int_len,
    output logic asleep,
    output logic soft_overrange,
    output logic [3:0] gp_out
);
    // ---------------- link domain (sclk) ----------------
    logic [7:0] shift_r;
    logic [2:0] bit_idx_r;
    logic [7:0] tx_snap_r;

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            shift_r <= 8'h00;
        end else if (!cs_n) begin
            shift_r <= {shift_r[6:0], sdi};
        end
    end

    logic [2:0] rx_cnt_r;
    logic [7:0] word_r;

    always_ff @(posedge sclk or posedge rst or posedge cs_n) begin
        if (rst || cs_n) begin
            rx_cnt_r <= 3'h0;
        end else begin
            rx_cnt_r <= rx_cnt_r + 3'h1;
        end
    end

    // whole word held from the eighth rise
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            word_r <= 8'h00;
        end else if (!cs_n && rx_cnt_r == 3'h7) begin
            word_r <= {shift_r[6:0], sdi};
        end
    end

    // out bit advances on falling edge
    always_ff @(negedge sclk or posedge rst or posedge cs_n) begin
        if (rst || cs_n) begin
            bit_idx_r <= 3'h0;
        end else begin
            bit_idx_r <= bit_idx_r + 3'h1;
        end
    end

    // link logic never gated by sleep
    assign sdo = tx_snap_r[3'h7 - bit_idx_r];
    assign sdo_oe_n = cs_n;

    // ---------------- core domain (clk) ----------------
    logic cs_s1_r, cs_s2_r, cs_s3_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end
    logic frame_end;
    logic in_frame;
    assign frame_end = cs_s2_r && !cs_s3_r;
    assign in_frame = !cs_s2_r;

    // word_r settles long before the synced frame end reads it
    msac_pkg::msac_cmd0_t cmd;
    assign cmd = msac_pkg::msac_cmd0_t'(word_r);

    logic [1:0] sel_r;
    logic start_r, sleep_r, zero_r;
    logic [10:0] int_len_r;
    logic [3:0] gp_r;
    logic [10:0] cnt_r, cnt_nxt;
    logic [2:0] age_r;
    logic asleep_r;
    logic eoc_r;
    logic wr0, wr1;
    logic launch;
    assign wr0 = frame_end && !cmd.word_sel;
    assign wr1 = frame_end && cmd.word_sel;
    assign launch = start_r && cnt_r == msac_pkg::CNT_ZERO && !asleep_r
        && age_r == 3'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_r <= msac_pkg::SEL_LOW;
        end else if (wr0) begin
            sel_r <= {cmd.reg_select_hi, cmd.reg_select_lo};
        end
    end

    // sleep request and read-zero from word zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_r <= 1'b0;
            zero_r <= 1'b0;
        end else if (wr0) begin
            sleep_r <= cmd.sleep;
            zero_r <= cmd.read_zero;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_len_r <= msac_pkg::INT_LEN_60;
        end else if (wr0) begin
            int_len_r <= cmd.hz50 ? msac_pkg::INT_LEN_50 : msac_pkg::INT_LEN_60;
        end
    end
    assign int_len = int_len_r;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_gp
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    gp_r[g] <= 1'b0;
                end else if (wr1) begin
                    gp_r[g] <= word_r[4 + g];
                end
            end
        end
    endgenerate
    assign gp_out = gp_r;

    assign input_short = zero_r;

    // start cleared five cycles after use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_r <= 1'b0;
            age_r <= 3'h0;
        end else begin
            if (launch || age_r != 3'h0) begin
                age_r <= (age_r == msac_pkg::START_HOLD) ? 3'h0 : age_r + 3'h1;
            end
            if (frame_end && !cmd.word_sel && cmd.start) begin
                start_r <= 1'b1;
            end else if (age_r == msac_pkg::START_HOLD) begin
                start_r <= 1'b0;
            end
        end
    end

    // launch only at 0000, load 0001
    // one conversion, then wait at 0000
    always_comb begin
        cnt_nxt = cnt_r;
        if (launch) begin
            cnt_nxt = msac_pkg::CNT_FIRST;
        end else if (cnt_r != msac_pkg::CNT_ZERO) begin
            cnt_nxt = cnt_r + 11'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= msac_pkg::CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eoc_r <= 1'b1;
        end else begin
            eoc_r <= cnt_nxt == msac_pkg::CNT_ZERO;
        end
    end
    assign eoc = eoc_r;

    // conversion phases, gray coded except the PH_DEINT to PH_ZERO step
    typedef enum logic [1:0] {
        PH_ZERO = 2'b00,
        PH_INTEG = 2'b01,
        PH_DEINT = 2'b11
    } msac_phase_t;
    msac_phase_t phase_r;
    logic [10:0] int_end;
    assign int_end = msac_pkg::INT_BEGIN + int_len_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= PH_ZERO;
        end else begin
            unique case (phase_r)
                PH_ZERO: begin
                    if (cnt_nxt == msac_pkg::INT_BEGIN) begin
                        phase_r <= PH_INTEG;
                    end
                end
                PH_INTEG: begin
                    if (cnt_nxt >= int_end) begin
                        phase_r <= PH_DEINT;
                    end
                end
                PH_DEINT: begin
                    if (cnt_nxt == msac_pkg::CNT_ZERO) begin
                        phase_r <= PH_ZERO;
                    end
                end
                default: phase_r <= PH_ZERO;
            endcase
        end
    end
    assign integrating = phase_r == PH_INTEG;

    // sleep once eoc high; counter stops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            asleep_r <= 1'b0;
        end else begin
            asleep_r <= sleep_r && eoc;
        end
    end
    assign asleep = asleep_r;

    // results latched as the counter wraps to 0000
    logic conv_end;
    assign conv_end = cnt_r == 11'h7ff;
    logic [18:0] mag_r;
    logic neg_r, soft_r;

    // clamp at hard limit, flag soft range
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mag_r <= 19'h00000;
            neg_r <= 1'b0;
            soft_r <= 1'b0;
        end else if (conv_end) begin
            mag_r <= (result_in.mag > msac_pkg::HARD_OVR) ? msac_pkg::HARD_OVR
                : result_in.mag;
            neg_r <= result_in.negative;
            soft_r <= result_in.mag >= msac_pkg::SOFT_OVR;
        end
    end
    assign soft_overrange = soft_r;

    // collision: results changed while a frame was open
    logic coll_pend_r, coll_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coll_pend_r <= 1'b0;
        end else if (conv_end && in_frame) begin
            coll_pend_r <= 1'b1;
        end else if (frame_end) begin
            coll_pend_r <= 1'b0;
        end
    end

    // status read clears collision; set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coll_r <= 1'b0;
        end else if (frame_end && (coll_pend_r || (conv_end && in_frame))) begin
            coll_r <= 1'b1;
        end else if (frame_end && sel_r == msac_pkg::SEL_STAT) begin
            coll_r <= 1'b0;
        end
    end

    msac_pkg::msac_status_t stat;
    assign stat = '{collision: coll_r, eoc: eoc, integrating: integrating,
        asleep: asleep_r, negative: neg_r, low_bits: mag_r[2:0]};

    function automatic logic [7:0] pick(input logic [1:0] s,
        input logic [18:0] m, input logic [7:0] st);
        unique case (s)
            msac_pkg::SEL_LOW: pick = m[10:3];
            msac_pkg::SEL_HIGH: pick = m[18:11];
            msac_pkg::SEL_STAT: pick = st;
            msac_pkg::SEL_BAD: pick = msac_pkg::BAD_BYTE;
        endcase
    endfunction

    // byte frozen for the whole frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_snap_r <= 8'h00;
        end else if (!in_frame) begin
            tx_snap_r <= pick(sel_r, mag_r, stat);
        end
    end
endmodule

// ### tb/msac_chk.sv
// port assertions for the adc command control
// assumes binding to msac_top, all checks on clk
`timescale 1ns/1ps
module msac_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic eoc,
    input wire logic integrating,
    input wire logic input_short,
    input wire logic [10:0] int_len,
    input wire logic asleep,
    input wire logic soft_overrange,
    input wire logic [3:0] gp_out
);
    logic [11:0] low_cnt_r;
    logic [11:0] int_cnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) low_cnt_r <= 12'h000;
        else low_cnt_r <= eoc ? 12'h000 : low_cnt_r + 12'h001;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) int_cnt_r <= 12'h000;
        else int_cnt_r <= integrating ? int_cnt_r + 12'h001 : 12'h000;
    end
    chk_conv_length: assert property ($rose(eoc) |-> low_cnt_r == 12'h7ff)
        else $error("conversion span wrong");
    chk_integ_length: assert property ($fell(integrating) |-> int_cnt_r == {1'b0, int_len})
        else $error("integrate span wrong");
    chk_integ_start: assert property ($rose(integrating) |-> $past(eoc, 16))
        else $error("integrate start wrong");
    chk_integ_in_conv: assert property (integrating |-> !eoc)
        else $error("integrating while idle");
    chk_sleep_at_eoc: assert property (asleep |-> eoc)
        else $error("asleep mid conversion");
    chk_gp_at_frame: assert property ($changed(gp_out) |-> $past(cs_n))
        else $error("gp change outside frame end");
    chk_cfg_at_frame: assert property ($changed(int_len) || $changed(input_short) |-> $past(cs_n))
        else $error("setting change outside frame end");
    chk_ovr_at_eoc: assert property ($changed(soft_overrange) |-> eoc || $past(eoc))
        else $error("overrange change mid conversion");
    cover property ($rose(eoc));
    cover property ($rose(asleep));
    cover property ($rose(soft_overrange));
endmodule
bind msac_top msac_chk u_chk(.clk(clk), .rst(rst), .cs_n(cs_n), .eoc(eoc),
    .integrating(integrating), .input_short(input_short), .int_len(int_len),
    .asleep(asleep), .soft_overrange(soft_overrange), .gp_out(gp_out));

// ### tb/msac_host.sv
// host model on the serial command link
// assumes sclk idles low and runs only inside a frame
`timescale 1ns/1ps
module msac_host (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #16 sclk = 1'b1;
            rx[i] = sdo;
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        sdi = ~sdi;
        #100;
    endtask
endmodule

// ### tb/test_multislope_adc_command_control.sv
// command and read sequences for the adc control
// assumes host model drives the link, bench drives clk side
`timescale 1ns/1ps
module test_multislope_adc_command_control;
    logic clk, rst, sclk, cs_n, sdi, sdo, sdo_oe_n;
    logic eoc, integrating, input_short, asleep, soft_overrange;
    logic [10:0] int_len;
    logic [3:0] gp_out;
    logic [7:0] rx;
    logic [18:0] mag;
    msac_pkg::msac_result_t result_in;
    int n_fail, tests_run, cyc;
    msac_top uut(.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .result_in(result_in), .eoc(eoc), .integrating(integrating),
        .input_short(input_short), .int_len(int_len), .asleep(asleep),
        .soft_overrange(soft_overrange), .gp_out(gp_out));
    msac_host host(.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xr(input logic [7:0] tx, input logic [7:0] exp);
        host.xfer(tx, rx);
        chk({3'h0, rx}, {3'h0, exp});
    endtask
    task automatic wait_eoc();
        for (int k = 0; k < 3000 && eoc !== 1'b1; k++) @(negedge clk);
    endtask
    function automatic logic [7:0] st(input logic slp);
        return {3'b010, slp, 1'b1, mag[2:0]};
    endfunction
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        rst = 1'b1;
        n_fail = 0;
        tests_run = 0;
        cyc = 0;
        mag = 19'h12345;
        result_in = {1'b1, mag};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(11'(eoc), 11'h1);
        chk(int_len, msac_pkg::INT_LEN_60);
        xr(8'hf1, 8'h00);
        chk(11'(gp_out), 11'h00f);
        xr(8'h5a, 8'h00);
        chk(int_len, msac_pkg::INT_LEN_50);
        chk(11'(input_short), 11'h1);
        xr(8'h51, 8'h40);
        chk(11'(gp_out), 11'h005);
        xr(8'h80, 8'h40);
        chk(11'(input_short), 11'h0);
        chk(11'(eoc), 11'h0);
        wait_eoc();
        xr(8'h04, mag[10:3]);
        xr(8'h02, mag[18:11]);
        xr(8'h06, st(1'b0));
        xr(8'h00, 8'h00);
        chk(11'(soft_overrange), 11'h0);
        xr(8'h80, mag[10:3]);
        mag = msac_pkg::SOFT_OVR;
        result_in = {1'b1, mag};
        repeat (200) @(negedge clk);
        xr(8'h80, 8'h68);
        wait_eoc();
        repeat (3) @(negedge clk);
        chk(11'(eoc), 11'h0);
        chk(11'(soft_overrange), 11'h1);
        wait_eoc();
        repeat (20) @(negedge clk);
        chk(11'(eoc), 11'h1);
        xr(8'h22, mag[10:3]);
        chk(11'(asleep), 11'h1);
        xr(8'h01, st(1'b1));
        xr(8'h00, st(1'b1));
        chk(11'(asleep), 11'h0);
        repeat (2100) @(negedge clk);
        xr(8'h80, mag[10:3]);
        mag = 19'h7ffff;
        result_in = {1'b0, mag};
        wait_eoc();
        chk(11'(soft_overrange), 11'h1);
        xr(8'h04, msac_pkg::HARD_OVR[10:3]);
        xr(8'h00, msac_pkg::HARD_OVR[18:11]);
        tally_and_finish;
    end
endmodule
